// ### pkg/pcr_map.svh
`ifndef PCR_MAP_SVH
`define PCR_MAP_SVH
// register addresses (8-bit register index on the device register port)
`define PCR_ADDR_PROTECT    8'h25
`define PCR_ADDR_IFACE      8'h26
`define PCR_ADDR_SPTR       8'h2B
`define PCR_ADDR_SWORD      8'h2C
`define PCR_ADDR_BCAST      8'h50
// reset values
`define PCR_RST_WORD        16'h0000
// protect_mode_config fields
`define PCR_PROT_ACT_HI     9
`define PCR_PROT_ACT_LO     8
`define PCR_PROT_RSV_HI     15
`define PCR_PROT_RSV_LO     5
// interface_options fields
`define PCR_IF_TIMEOUT_BIT  12
`define PCR_IF_RSV_BIT      8
`define PCR_IF_FAST_BIT     2
`define PCR_IF_SDO_BIT      0
// scratch pointer and word
`define PCR_SPTR_HI         7
`define PCR_SPTR_LO         0
// broadcast code field, left aligned
`define PCR_BCAST_HI        15
`define PCR_BCAST_LO        6
`define PCR_BCAST_KEEP_LO   4
// shared pin input function code for protect
`define PCR_PIN_FUNC_PROT   4'h5
// protect sequence: cycles a slew step is held before power-down
`define PCR_SLEW_STEP_NS    1000
`define PCR_CLK_NS          10
`define PCR_SLEW_CYCLES     (`PCR_SLEW_STEP_NS / `PCR_CLK_NS)
`endif

// ### pkg/pcr_pkg.sv
package pcr_pkg;
	// protect action selections
	typedef enum logic [1:0] {
		PCR_ACT_HIZ,
		PCR_ACT_NVM,
		PCR_ACT_MLOW,
		PCR_ACT_MHIGH
	} pcr_action_e;

	// output stage request issued during a protect sequence
	typedef enum logic [2:0] {
		PCR_OUT_RUN,
		PCR_OUT_LOAD_NVM,
		PCR_OUT_SLEW_LOW,
		PCR_OUT_SLEW_HIGH,
		PCR_OUT_HIZ
	} pcr_out_e;
endpackage : pcr_pkg

// ### core/pcr_protect_seq.sv
`timescale 1ns/1ps
`include "pcr_map.svh"
module pcr_protect_seq #(
	parameter int SLEW_CYCLES = `PCR_SLEW_CYCLES // cycles spent slewing
) (
	input  wire logic       mclk,        // system clock
	input  wire logic       reset,       // sync reset, active high
	input  wire logic       trigger,     // one-cycle protect start
	input  wire logic [1:0] action,      // selected protect action
	output logic      [2:0] out_request, // request to output stages
	output logic            busy         // sequence in progress
);
	initial begin
		if (SLEW_CYCLES < 1) $error("SLEW_CYCLES must be at least one");
	end

	typedef enum logic [1:0] {ST_IDLE, ST_PRE, ST_HIZ} pcr_seq_e;

	pcr_seq_e    state, next_state;          // sequence state
	logic [2:0]  req, next_req;              // registered output request
	logic [31:0] cnt, next_cnt;              // slew step counter

	// next-state logic of the protect sequence
	always_comb begin
		next_state = state;
		next_req   = req;
		next_cnt   = cnt;
		case (state)
			ST_IDLE: begin
				if (trigger) begin
					next_cnt = 32'h00000000;
					case (action)
						2'h0: begin // straight to hi-z
							next_state = ST_HIZ;
							next_req   = 3'(pcr_pkg::PCR_OUT_HIZ);
						end
						2'h1: begin // nvm code, no slew
							next_state = ST_PRE;
							next_req   = 3'(pcr_pkg::PCR_OUT_LOAD_NVM);
							next_cnt   = 32'(SLEW_CYCLES - 1);
						end
						2'h2: begin // slew to margin low
							next_state = ST_PRE;
							next_req   = 3'(pcr_pkg::PCR_OUT_SLEW_LOW);
						end
						default: begin // slew to margin high
							next_state = ST_PRE;
							next_req   = 3'(pcr_pkg::PCR_OUT_SLEW_HIGH);
						end
					endcase
				end
			end
			ST_PRE: begin
				// hold the pre-step, then power down
				if (cnt >= 32'(SLEW_CYCLES - 1)) begin
					next_state = ST_HIZ;
					next_req   = 3'(pcr_pkg::PCR_OUT_HIZ);
				end else begin
					next_cnt = cnt + 32'h00000001;
				end
			end
			ST_HIZ: begin
				// stays powered down until reset
				next_req = 3'(pcr_pkg::PCR_OUT_HIZ);
			end
			default: begin
				next_state = ST_IDLE;
				next_req   = 3'(pcr_pkg::PCR_OUT_RUN);
			end
		endcase
	end

	// state registers
	always_ff @(posedge mclk) begin
		if (reset) begin
			state <= ST_IDLE;
			req   <= 3'h0;
			cnt   <= 32'h00000000;
		end else begin
			state <= next_state;
			req   <= next_req;
			cnt   <= next_cnt;
		end
	end

	assign out_request = req;
	assign busy        = (state == ST_PRE);
endmodule : pcr_protect_seq

// ### core/pcr_regs.sv
`timescale 1ns/1ps
`include "pcr_map.svh"
// Summary of operation
// - action 00 hi-z; 01 nvm code then hi-z
// - action 10/11 slew margin low/high, hi-z
// - bit 2 selects fast serial output
// - bit 0 enables serial out on pin
// - pointer write selects next scratch location
// - scratch write advances pointer by one
// - scratch word writes and reads selected location
// - broadcast write loads every enabled channel together
// - 10-bit code left aligned, low bits ignored
// - load only channels with broadcast enable
// - falling pin edge starts protect when configured
module pcr_regs #(
	parameter int CHANNELS    = 3,                // dac channel count
	parameter int SCR_DEPTH   = 256,              // scratch words
	parameter int SLEW_CYCLES = `PCR_SLEW_CYCLES  // protect pre-step cycles
) (
	input  wire logic                  mclk,                     // system clock
	input  wire logic                  reset,                    // sync reset, active high
	input  wire logic [7:0]            reg_addr,                 // register index
	input  wire logic [15:0]           reg_wdata,                // write data
	input  wire logic                  reg_write,                // write strobe
	input  wire logic                  reg_read,                 // read strobe
	output logic      [15:0]           reg_rdata,                // read data, registered
	input  wire logic                  shared_io_pin,            // shared pin level in
	input  wire logic                  pin_input_enable,         // pin used as input
	input  wire logic [3:0]            pin_input_function,       // pin input function code
	input  wire logic [CHANNELS-1:0]   channel_broadcast_enable, // per-channel follow
	input  wire logic                  spi_read_data,            // serial read-back bit
	output logic                       shared_io_out,            // pin output value
	output logic                       shared_io_oe,             // pin output enable
	output logic                       i2c_timeout_enable,       // bus timeout active
	output logic                       fast_serial_out_enable,   // fast serial timing
	output logic [CHANNELS-1:0]        channel_load,             // broadcast load pulse
	output logic [9:0]                 broadcast_code,           // common channel code
	output logic [2:0]                 protect_out_request,      // protect request
	output logic                       protect_busy              // protect sequence busy
);
	localparam int PW = $clog2(SCR_DEPTH);

	initial begin
		if (SCR_DEPTH < 2 || SCR_DEPTH > 256) $error("SCR_DEPTH must be 2..256");
		// the pointer wraps at its own width, so every index must name an entry
		if ((SCR_DEPTH & (SCR_DEPTH - 1)) != 0) $error("SCR_DEPTH must be a power of two");
		if (CHANNELS < 1) $error("CHANNELS must be at least one");
	end

	logic [15:0]          protect_mode_config, next_protect_mode_config; // protect action reg
	logic [15:0]          interface_options, next_interface_options;     // interface reg
	logic [PW-1:0]        scratch_pointer, next_scratch_pointer;         // scratch pointer
	logic [15:0]          all_channel_code, next_all_channel_code;       // broadcast reg
	logic [15:0]          scratch_mem [SCR_DEPTH];                       // scratch storage
	logic [15:0]          next_rdata;                                    // read mux
	logic [CHANNELS-1:0]  next_load;                                     // load pulses
	logic                 pin_q, next_pin_q;                             // previous pin level
	logic                 prot_trig;                                     // protect start pulse
	logic                 wr_scr;                                        // scratch write
	logic                 rd_scr;                                        // scratch read

	assign wr_scr = reg_write && (reg_addr == `PCR_ADDR_SWORD);
	assign rd_scr = reg_read && (reg_addr == `PCR_ADDR_SWORD);

	// next values of the register bank and read port
	always_comb begin
		next_protect_mode_config = protect_mode_config;
		next_interface_options   = interface_options;
		next_scratch_pointer     = scratch_pointer;
		next_all_channel_code    = all_channel_code;
		next_load                = '0;
		next_rdata               = reg_rdata;
		next_pin_q               = shared_io_pin;
		if (reg_write) begin
			case (reg_addr)
				`PCR_ADDR_PROTECT: begin
					next_protect_mode_config = {reg_wdata[15:5], 5'h00};
				end
				`PCR_ADDR_IFACE: begin
					next_interface_options = reg_wdata & 16'h1105;
				end
				`PCR_ADDR_SPTR: begin
					next_scratch_pointer = reg_wdata[PW-1:0];
				end
				`PCR_ADDR_SWORD: begin
					next_scratch_pointer = scratch_pointer + PW'(1);
				end
				`PCR_ADDR_BCAST: begin
					next_all_channel_code = {reg_wdata[15:4], 4'h0};
					next_load             = channel_broadcast_enable;
				end
				default: begin
					next_load = '0; // unmapped write ignored
				end
			endcase
		end
		if (reg_read) begin
			case (reg_addr)
				`PCR_ADDR_PROTECT: next_rdata = protect_mode_config;
				`PCR_ADDR_IFACE:   next_rdata = interface_options;
				`PCR_ADDR_SPTR:    next_rdata = 16'(scratch_pointer);
				`PCR_ADDR_SWORD:   next_rdata = scratch_mem[scratch_pointer];
				`PCR_ADDR_BCAST:   next_rdata = all_channel_code;
				default:           next_rdata = 16'h0000; // unmapped reads zero
			endcase
		end
	end

	// register bank and pin history
	always_ff @(posedge mclk) begin
		if (reset) begin
			protect_mode_config <= `PCR_RST_WORD;
			interface_options   <= `PCR_RST_WORD;
			scratch_pointer     <= '0;
			all_channel_code    <= `PCR_RST_WORD;
			channel_load        <= '0;
			reg_rdata           <= 16'h0000;
			pin_q               <= 1'b1;
		end else begin
			protect_mode_config <= next_protect_mode_config;
			interface_options   <= next_interface_options;
			scratch_pointer     <= next_scratch_pointer;
			all_channel_code    <= next_all_channel_code;
			channel_load        <= next_load;
			reg_rdata           <= next_rdata;
			pin_q               <= next_pin_q;
		end
	end

	// scratch storage, one entry per index; not reset
	always_ff @(posedge mclk) begin
		if (wr_scr) begin
			scratch_mem[scratch_pointer] <= reg_wdata;
		end
	end

	// falling edge on the pin while configured as protect input
	assign prot_trig = pin_input_enable && (pin_input_function == `PCR_PIN_FUNC_PROT)
		&& pin_q && !shared_io_pin;

	// interface option outputs
	assign i2c_timeout_enable     = interface_options[`PCR_IF_TIMEOUT_BIT];
	assign fast_serial_out_enable = interface_options[`PCR_IF_FAST_BIT];
	assign shared_io_oe           = interface_options[`PCR_IF_SDO_BIT];
	assign shared_io_out          = interface_options[`PCR_IF_SDO_BIT] & spi_read_data;
	assign broadcast_code         = all_channel_code[`PCR_BCAST_HI:`PCR_BCAST_LO];

	// protect sequencer
	pcr_protect_seq #(
		.SLEW_CYCLES (SLEW_CYCLES)
	) u_seq (
		.mclk        (mclk),
		.reset       (reset),
		.trigger     (prot_trig),
		.action      (protect_mode_config[`PCR_PROT_ACT_HI:`PCR_PROT_ACT_LO]),
		.out_request (protect_out_request),
		.busy        (protect_busy)
	);
endmodule : pcr_regs

// ### testbench/pcr_regs_asserts.sv
`timescale 1ns/1ps
`include "pcr_map.svh"
module pcr_regs_asserts #(
	parameter int CHANNELS = 3 // dac channel count
) (
	input wire logic                mclk,                     // system clock
	input wire logic                reset,                    // sync reset, active high
	input wire logic                reg_write,                // write strobe
	input wire logic                reg_read,                 // read strobe
	input wire logic [7:0]          reg_addr,                 // register index
	input wire logic [15:0]         reg_wdata,                // write data
	input wire logic [15:0]         reg_rdata,                // read data
	input wire logic                shared_io_pin,            // pin level in
	input wire logic                pin_input_enable,         // pin used as input
	input wire logic [3:0]          pin_input_function,       // pin function code
	input wire logic [CHANNELS-1:0] channel_broadcast_enable, // channel follow
	input wire logic [CHANNELS-1:0] channel_load,             // load pulses
	input wire logic                shared_io_out,            // pin output value
	input wire logic                shared_io_oe,             // pin output enable
	input wire logic                i2c_timeout_enable,       // bus timeout option
	input wire logic                fast_serial_out_enable,   // fast serial option
	input wire logic [9:0]          broadcast_code,           // common code
	input wire logic [2:0]          protect_out_request       // protect request
);
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	logic [1:0] act_q; // shadow of the protect action field
	wire wr_if = reg_write && reg_addr == `PCR_ADDR_IFACE; // option write
	wire wr_bc = reg_write && reg_addr == `PCR_ADDR_BCAST; // broadcast write
	// shadow copy so the protect start can be predicted
	always_ff @(posedge mclk) begin
		if (reset) act_q <= 2'h0;
		else if (reg_write && reg_addr == `PCR_ADDR_PROTECT) act_q <= reg_wdata[9:8];
	end
	a_sdo_enable: assert property (wr_if |=> shared_io_oe == $past(reg_wdata[0])) else $error("pin enable wrong");
	a_timeout_enable: assert property (wr_if |=> i2c_timeout_enable == $past(reg_wdata[12])) else $error("timeout wrong");
	a_fast_serial: assert property (wr_if |=> fast_serial_out_enable == $past(reg_wdata[2])) else $error("fast wrong");
	a_sdo_gated: assert property (!shared_io_oe |-> !shared_io_out) else $error("pin driven while off");
	a_bcast_load: assert property (wr_bc |=> channel_load == $past(channel_broadcast_enable)
		&& broadcast_code == $past(reg_wdata[15:6])) else $error("broadcast wrong");
	a_no_stray_load: assert property (!wr_bc |=> channel_load == '0) else $error("stray load");
	a_prot_start: assert property ($fell(shared_io_pin) && pin_input_enable && pin_input_function == 4'h5
		&& protect_out_request == 3'h0 |=> protect_out_request ==
		($past(act_q) == 2'h0 ? 3'h4 : {1'b0, $past(act_q)})) else $error("protect start wrong");
	a_pre_step_ends: assert property (protect_out_request inside {3'h1, 3'h2, 3'h3}
		|-> ##[1:8] protect_out_request == 3'h4) else $error("no power-down");
	a_hiz_holds: assert property (protect_out_request == 3'h4 |=> protect_out_request == 3'h4) else $error("hi-z lost");
	a_rdata_holds: assert property (!reg_read |=> $stable(reg_rdata)) else $error("read data moved");
endmodule : pcr_regs_asserts
bind pcr_regs pcr_regs_asserts #(.CHANNELS(CHANNELS)) pcr_regs_asserts_i (.*);

// ### testbench/pcr_host.sv
`timescale 1ns/1ps
module pcr_host (
	input  wire logic  mclk,      // system clock
	output logic [7:0] reg_addr,  // register index
	output logic [15:0] reg_wdata, // write data
	output logic       reg_write, // write strobe
	output logic       reg_read   // read strobe
);
	// idle bus at time zero
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 16'h0000;
		reg_write = 1'b0;
		reg_read = 1'b0;
	end
	// one-cycle access; lines show inverted garbage once released
	task automatic access(input logic [7:0] a, input logic [15:0] d, input logic w);
		@(negedge mclk);
		reg_addr = a;
		reg_wdata = d;
		reg_write = w;
		reg_read = !w;
		@(negedge mclk);
		reg_write = 1'b0;
		reg_read = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask : access
endmodule : pcr_host

// ### testbench/pcr_regs_tb.sv
`timescale 1ns/1ps
`include "pcr_map.svh"
module pcr_regs_tb;
	logic mclk = 1'b0, reset = 1'b1, reg_write, reg_read, rd_q = 1'b0; // clock, reset, strobes
	logic [7:0]  reg_addr;                                // register index
	logic [15:0] reg_wdata, reg_rdata, exp_q[$], w[3];    // data and expectations
	logic shared_io_pin = 1'b1, pin_input_enable = 1'b0, spi_read_data = 1'b1; // pin inputs
	logic [3:0]  pin_input_function = 4'h0;               // pin function
	logic [2:0]  channel_broadcast_enable = 3'h0, channel_load, protect_out_request; // channels
	logic [9:0]  broadcast_code;                          // common code
	logic shared_io_out, shared_io_oe, i2c_timeout_enable, fast_serial_out_enable, protect_busy; // outputs
	logic [7:0]  regs[5] = '{`PCR_ADDR_PROTECT, `PCR_ADDR_IFACE, `PCR_ADDR_SPTR, `PCR_ADDR_BCAST, 8'h30};
	int failures = 0, num_checks = 0, seed = 45442;       // counters and seed
	always #5 mclk = ~mclk;
	pcr_regs #(.SLEW_CYCLES(2)) pcr_regs_i (.*);
	pcr_host pcr_host_i (.*);
	// compare and count
	task automatic check(input string n, input logic [15:0] s, input logic [15:0] e);
		num_checks++;
		if (s !== e) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask : check
	// read request notes its expectation first
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		exp_q.push_back(e);
		pcr_host_i.access(a, 16'h0000, 1'b0);
	endtask : rd
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		pcr_host_i.access(a, d, 1'b1);
	endtask : wr
	// answer monitor: oldest note against each read answer
	always @(posedge mclk) rd_q <= reg_read;
	always @(negedge mclk) begin
		if (rd_q) check("reg_rdata", reg_rdata, exp_q.pop_front());
	end
	task automatic do_reset;
		reset = 1'b1;
		repeat (6) @(negedge mclk);
		reset = 1'b0;
	endtask : do_reset
	task automatic stop_test;
		if (failures == 0 && num_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : stop_test
	// watchdog against a hung handshake
	initial begin
		#200000;
		failures++;
		stop_test;
	end
	// one protect run per action, other function first
	task automatic protect(input logic [1:0] act);
		int n;
		do_reset;
		wr(`PCR_ADDR_PROTECT, {6'h00, act, 8'h00});
		pin_input_enable = 1'b1;
		pin_input_function = 4'h4;
		shared_io_pin = 1'b0;
		repeat (2) @(negedge mclk);
		shared_io_pin = 1'b1;
		pin_input_function = 4'h5;
		repeat (3) @(negedge mclk);
		check("idle_req", protect_out_request, 16'h0000);
		shared_io_pin = 1'b0;
		@(negedge mclk);
		check("first_req", protect_out_request, act == 2'h0 ? 16'h0004 : {14'h0, act});
		check("busy", protect_busy, 16'(act != 2'h0));
		n = 0;
		while (protect_out_request !== 3'h4 && n < 20) begin
			@(negedge mclk);
			n++;
		end
		check("final_req", protect_out_request, 16'h0004);
		shared_io_pin = 1'b1;
	endtask : protect
	initial begin
		do_reset;
		foreach (regs[i]) rd(regs[i], 16'h0000);
		wr(`PCR_ADDR_IFACE, 16'hFFFF);
		check("oe", shared_io_oe, 16'h0001);
		check("out", shared_io_out, 16'h0001);
		check("tmo", i2c_timeout_enable, 16'h0001);
		check("fast", fast_serial_out_enable, 16'h0001);
		spi_read_data = 1'b0;
		@(negedge mclk);
		check("out_bit", shared_io_out, 16'h0000);
		spi_read_data = 1'b1;
		rd(`PCR_ADDR_IFACE, 16'h1105);
		wr(`PCR_ADDR_IFACE, 16'h0000);
		check("out_off", shared_io_out, 16'h0000);
		check("oe_off", shared_io_oe, 16'h0000);
		check("tmo_off", i2c_timeout_enable, 16'h0000);
		check("fast_off", fast_serial_out_enable, 16'h0000);
		wr(`PCR_ADDR_PROTECT, 16'hFFFF);
		rd(`PCR_ADDR_PROTECT, 16'hFFE0);
		// scratch fill across the pointer wrap
		wr(`PCR_ADDR_SPTR, 16'h00FE);
		for (int i = 0; i < 3; i++) begin
			w[i] = 16'($random(seed));
			wr(`PCR_ADDR_SWORD, w[i]);
		end
		rd(`PCR_ADDR_SPTR, 16'h0001);
		wr(`PCR_ADDR_SPTR, 16'h00FE);
		rd(`PCR_ADDR_SWORD, w[0]);
		rd(`PCR_ADDR_SWORD, w[0]);
		rd(`PCR_ADDR_SPTR, 16'h00FE);
		wr(`PCR_ADDR_SPTR, 16'h00FF);
		rd(`PCR_ADDR_SWORD, w[1]);
		wr(`PCR_ADDR_SPTR, 16'h0000);
		rd(`PCR_ADDR_SWORD, w[2]);
		// every enable pattern with a random code
		for (int i = 0; i < 8; i++) begin
			channel_broadcast_enable = 3'(i);
			w[0] = 16'($random(seed));
			wr(`PCR_ADDR_BCAST, w[0]);
			check("load", channel_load, 16'(i));
			check("code", broadcast_code, {6'h00, w[0][15:6]});
			rd(`PCR_ADDR_BCAST, w[0] & 16'hFFF0);
		end
		for (int a = 0; a < 4; a++) protect(2'(a));
		stop_test;
	end
endmodule : pcr_regs_tb
